// ### bench/rtcai_alarm_timer_tb.sv
// Self-checking bench for the alarm and periodic timer block
`timescale 1ns/1ps
module rtcai_alarm_timer_tb;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic ce = 1'b1;
	logic [7:0] regAddr = 8'h00;
	rtcai_pkg::rtcai_byte_t regWdata = 8'h00;
	rtcai_pkg::rtcai_byte_t regRdata;
	logic scl, minuteTick, irqOut, irqOeN;
	logic [4:0] srcTick;
	logic [6:0] curMinute, m;
	logic [5:0] curHour, curDate, h, d;
	logic [2:0] curWeekday, w;
	logic [7:0] r = 8'h62;
	logic [7:0] q, v;
	int n, n_mismatch = 0, tests_run = 0;
	always #12.5 mclk = ~mclk;
	rtcai_far p
	(
		.mclk(mclk), .scl(scl), .srcTick(srcTick), .minuteTick(minuteTick),
		.curMinute(curMinute), .curHour(curHour),
		.curWeekday(curWeekday), .curDate(curDate)
	);
	// Short pin pulses keep the run brief
	rtcai_alarm_timer #(.TRTN_FAST_CYC(8), .TRTN_SLOW_CYC(16)) dut
	(
		.mclk(mclk), .nrst(nrst), .ce(ce), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .scl(scl), .srcTick(srcTick),
		.minuteTick(minuteTick), .curMinute(curMinute), .curHour(curHour),
		.curWeekday(curWeekday), .curDate(curDate), .irqOut(irqOut),
		.irqOeN(irqOeN)
	);
	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Alarm decision from the register settings and the new time
	function automatic logic hit(input logic [7:0] am, ah, ad, ex, ct,
		input logic [6:0] m, input logic [5:0] h, input logic [2:0] w,
		input logic [5:0] d);
		return !ct[1] && (am[7] || am[6:0] == m) && (ah[7] || ah[5:0] == h)
			&& (ad[7] || (ex[3] ? ad[5:0] == d : ad[w]));
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		@(posedge mclk);
		{regAddr, regWdata, regWr} <= {a, dv, 1'b1};
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic chkr(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		{regAddr, regRd} <= {a, 1'b1};
		@(posedge mclk);
		regRd <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	// Gate off while setting up, then one minute rollover
	task automatic alm(input logic [7:0] am, ah, ad, ex, ct,
		input logic [6:0] m, input logic [5:0] h, input logic [2:0] w,
		input logic [5:0] d);
		logic e;
		e = hit(am, ah, ad, ex, ct, m, h, w, d);
		wr(8'h0F, 8'h00);
		wr(8'h0E, 8'h00);
		wr(8'h08, am);
		wr(8'h09, ah);
		wr(8'h0A, ad);
		wr(8'h0D, ex);
		wr(8'h0F, ct);
		chkr(8'h09, ah & 8'hBF);
		chkr(8'h0A, ex[3] ? (ad & 8'hBF) : ad);
		p.step(m, h, w, d);
		chkr(8'h0E, {4'h0, e, 3'h0});
		chk({7'h0, irqOeN}, {7'h0, !(e && ct[3])});
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		wr(8'h20, 8'hFF);
		chkr(8'h20, 8'h00);
		// Strobes taken while the enable is low must be dropped
		wr(8'h08, 8'h55);
		ce <= 1'b0;
		wr(8'h08, 8'hAA);
		ce <= 1'b1;
		chkr(8'h08, 8'h55);
		r = nx(r);
		v = 8'h02 + {6'h0, r[1:0]};
		wr(8'h0B, v);
		wr(8'h0C, 8'h00);
		// Every source code; a partial count must not survive restart
		for (int s = 0; s < 5; s++)
		begin
			wr(8'h0D, 8'(s));
			wr(8'h0D, 8'(s) | 8'h10);
			p.tick(s);
			p.ack();
			repeat (4) @(posedge mclk);
			p.tick(s);
			p.tick((s + 1) % 5);
			chkr(8'h0B, v - 8'h01);
		end
		wr(8'h0F, 8'h10);
		wr(8'h0D, 8'h00);
		wr(8'h0D, 8'h10);
		p.ack();
		repeat (4) @(posedge mclk);
		for (int k = 0; k < v; k++)
			p.tick(0);
		// Pin looked at between edges, away from its own update
		n = 0;
		repeat (40) @(negedge mclk) n += (irqOeN === 1'b0);
		chk(8'(n), 8'h08);
		chkr(8'h0E, 8'h10);
		chkr(8'h0B, v);
		// Pause holds the count; stop still lets the fast source run
		wr(8'h0F, 8'h14);
		p.tick(0);
		chkr(8'h0B, v);
		wr(8'h0F, 8'h12);
		p.tick(0);
		chkr(8'h0B, v - 8'h01);
		wr(8'h0F, 8'h10);
		// Slow sources give the long pin pulse
		wr(8'h0D, 8'h00);
		wr(8'h0D, 8'h11);
		p.ack();
		repeat (4) @(posedge mclk);
		for (int k = 0; k < v; k++)
			p.tick(1);
		n = 0;
		repeat (40) @(negedge mclk) n += (irqOeN === 1'b0);
		chk(8'(n), 8'h10);
		wr(8'h0D, 8'h00);
		$display("timer tests done");
		alm(8'h80, 8'h80, 8'h80, 8'h00, 8'h08,
			7'h00, 6'h00, 3'h0, 6'h01);
		alm(8'h80, 8'h80, 8'h80, 8'h00, 8'h0A,
			7'h00, 6'h00, 3'h0, 6'h01);
		alm(8'h80, 8'h80, 8'h05, 8'h00, 8'h08,
			7'h00, 6'h00, 3'h2, 6'h14);
		alm(8'h80, 8'h80, 8'h05, 8'h00, 8'h08,
			7'h00, 6'h00, 3'h1, 6'h15);
		alm(8'h80, 8'h80, 8'h15, 8'h08, 8'h08,
			7'h00, 6'h00, 3'h2, 6'h14);
		alm(8'h80, 8'h80, 8'h15, 8'h08, 8'h08,
			7'h00, 6'h00, 3'h1, 6'h15);
		alm(8'h80, 8'h80, 8'h80, 8'h00, 8'h00,
			7'h00, 6'h00, 3'h0, 6'h01);
		alm(8'h80, 8'h80, 8'h80, 8'h00, 8'h08,
			7'h00, 6'h00, 3'h0, 6'h01);
		repeat (20) @(posedge mclk);
		chk({7'h0, irqOeN}, 8'h00);
		wr(8'h0E, 8'h08);
		chkr(8'h0E, 8'h08);
		wr(8'h0E, 8'h00);
		chkr(8'h0E, 8'h00);
		chk({7'h0, irqOeN}, 8'h01);
		alm(8'h80, 8'h80, 8'h80, 8'h00, 8'h08,
			7'h00, 6'h00, 3'h0, 6'h01);
		wr(8'h0F, 8'h00);
		chkr(8'h0E, 8'h08);
		chk({7'h0, irqOeN}, 8'h01);
		// Random times against random, partly excluded, alarm fields
		for (int i = 0; i < 24; i++)
		begin
			r = nx(r);
			q = nx(r);
			m = {1'b0, r[5:4], 1'b0, r[2:0]};
			h = {1'b0, r[0], 1'b0, r[3:1]};
			w = 3'(r % 7);
			d = {1'b0, r[7], 1'b0, r[6:4]};
			alm({q[0], m ^ {6'h0, q[1]}}, {q[2], q[7], h ^ {5'h0, q[3]}},
				q[4] ? {q[5], q[6], d} : {q[5], q[6:0]}, {4'h0, q[4], 3'h0},
				{4'h0, q[6], 1'b0, q[7] & q[5], 1'b0}, m, h, w, d);
		end
		// Alarm equal to the present time, every field able to match
		wr(8'h0E, 8'h00);
		wr(8'h08, {1'b0, curMinute});
		wr(8'h09, 8'h80);
		wr(8'h0A, 8'h80);
		wr(8'h0F, 8'h08);
		repeat (4) @(posedge mclk);
		chkr(8'h0E, 8'h00);
		chk({7'h0, irqOeN}, 8'h01);
		$display("alarm tests done");
		give_verdict();
	end
	// Hang guard
	initial
	begin
		#2000000;
		n_mismatch++;
		give_verdict();
	end
endmodule // rtcai_alarm_timer_tb

// ### bench/rtcai_chk.sv
// Port checker for the alarm and periodic timer interrupt block
`timescale 1ns/1ps
module rtcai_chk
(
	input wire logic                   mclk,
	input wire logic                   nrst,
	input wire logic [7:0]             regAddr,
	input wire rtcai_pkg::rtcai_byte_t regWdata,
	input wire logic                   regWr,
	input wire logic                   regRd,
	input wire rtcai_pkg::rtcai_byte_t regRdata,
	input wire logic                   minuteTick,
	input wire logic                   irqOut,
	input wire logic                   irqOeN
);
	logic [7:0] ctl, ext, aQ;
	logic       rdQ;
	logic [1:0] seen;
	////////////////////////////////////////////////////////////////////
	// Shadow of the gate bytes, so pin causes can be judged from ports
	always_ff @(posedge mclk)
	begin
		rdQ <= nrst && regRd;
		aQ <= regAddr;
		if (!nrst)
		begin
			ctl <= 8'h00;
			ext <= 8'h00;
		end
		else if (regWr && regAddr == 8'h0F)
			ctl <= regWdata;
		else if (regWr && regAddr == 8'h0D)
			ext <= regWdata;
	end
	// Flags once read as set; a write of zero forgets them
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			seen <= 2'h0;
		else if (regWr && regAddr == 8'h0E)
			seen <= seen & {regWdata[4], regWdata[3]};
		else if (rdQ && aQ == 8'h0E)
			seen <= seen | {regRdata[4], regRdata[3]};
	end
	////////////////////////////////////////////////////////////////////
	a_od_data: assert property (
		@(posedge mclk) disable iff (!nrst) irqOut == 1'b0)
		else $error("pin data not low");
	a_gate_off: assert property (
		@(posedge mclk) disable iff (!nrst)
		(ctl[4:3] == 2'h0) [*2] |-> irqOeN)
		else $error("pin low with both gates off");
	a_pin_cause: assert property (
		@(posedge mclk) disable iff (!nrst)
		$fell(irqOeN) |-> $past(ctl[4] || ctl[3]))
		else $error("pin fell without a gate");
	a_af_hold: assert property (
		@(posedge mclk) disable iff (!nrst)
		rdQ && aQ == 8'h0E && seen[0] |-> regRdata[3])
		else $error("alarm flag lost");
	a_tf_hold: assert property (
		@(posedge mclk) disable iff (!nrst)
		rdQ && aQ == 8'h0E && seen[1] |-> regRdata[4])
		else $error("timer flag lost");
	a_bit6_zero: assert property (
		@(posedge mclk) disable iff (!nrst)
		rdQ && (aQ == 8'h09 || aQ == 8'h0A && ext[3]) |-> !regRdata[6])
		else $error("unused bit six read as one");
	a_alarm_hold: assert property (
		@(posedge mclk) disable iff (!nrst)
		!irqOeN && !ctl[4] && ctl[3] && !regWr && !$past(regWr)
		|=> !irqOeN)
		else $error("alarm request dropped by itself");
	a_pin_clear: assert property (
		@(posedge mclk) disable iff (!nrst)
		regWr && regAddr == 8'h0E && !regWdata[3] && !ctl[4]
		&& !minuteTick ##1 !minuteTick && !ctl[4] |=> irqOeN)
		else $error("pin held after flag clear");
endmodule // rtcai_chk

bind rtcai_alarm_timer rtcai_chk u_chk
(
	.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.minuteTick(minuteTick), .irqOut(irqOut), .irqOeN(irqOeN)
);

// ### bench/rtcai_far.sv
// Time counters, source ticks and serial clock seen by the block
`timescale 1ns/1ps
module rtcai_far
(
	input wire logic  mclk,
	output logic      scl,
	output logic[4:0] srcTick,
	output logic      minuteTick,
	output logic[6:0] curMinute,
	output logic[5:0] curHour,
	output logic[2:0] curWeekday,
	output logic[5:0] curDate
);
	// Serial clock stands low outside frames
	initial
	begin
		scl = 1'b0;
		srcTick = 5'h00;
		minuteTick = 1'b0;
		{curMinute, curHour, curWeekday, curDate} = 22'h0;
	end
	// Counters roll into a new minute; the tick marks the change
	task automatic step(input logic [6:0] m, input logic [5:0] h,
		input logic [2:0] w, input logic [5:0] d);
		@(posedge mclk);
		{curMinute, curHour, curWeekday, curDate} <= {m, h, w, d};
		minuteTick <= 1'b1;
		@(posedge mclk);
		minuteTick <= 1'b0;
	endtask
	// One period of source s elapses
	task automatic tick(input int s);
		@(posedge mclk);
		srcTick[s] <= 1'b1;
		@(posedge mclk);
		srcTick <= 5'h00;
	endtask
	// Acknowledge clock that closes a write; off the mclk phase
	task automatic ack;
		#107 scl = 1'b1;
		#100 scl = 1'b0;
	endtask
endmodule // rtcai_far

// ### src/rtcai_alarm_timer.sv
// Alarm comparator, periodic countdown timer and interrupt request pin
`timescale 1ns/1ps
`include "rtcai_params.svh"

module rtcai_alarm_timer
#(
	parameter int TRTN_FAST_CYC = `RTCAI_TRTN_FAST_CYC,
	parameter int TRTN_SLOW_CYC = `RTCAI_TRTN_SLOW_CYC
)
(
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	input  wire logic                 ce,
	input  wire logic [7:0]           regAddr,
	input  wire rtcai_pkg::rtcai_byte_t regWdata,
	input  wire logic                 regWr,
	input  wire logic                 regRd,
	output rtcai_pkg::rtcai_byte_t    regRdata,
	input  wire logic                 scl,
	input  wire logic [4:0]           srcTick,
	input  wire logic                 minuteTick,
	input  wire logic [6:0]           curMinute,
	input  wire logic [5:0]           curHour,
	input  wire logic [2:0]           curWeekday,
	input  wire logic [5:0]           curDate,
	output logic                      irqOut,
	output logic                      irqOeN
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	rtcai_pkg::rtcai_byte_t  almMinute;
	rtcai_pkg::rtcai_byte_t  almHour;
	rtcai_pkg::rtcai_byte_t  almDay;
	rtcai_pkg::rtcai_byte_t  extCtrl;
	rtcai_pkg::rtcai_byte_t  intCtrl;
	rtcai_pkg::rtcai_count_t preset;
	rtcai_pkg::rtcai_count_t count;
	rtcai_pkg::rtcai_pulse_t pulseCnt;
	rtcai_pkg::rtcai_tmr_e   tmrState;
	rtcai_pkg::rtcai_byte_t  next_rdata;
	logic                    alarmFlag;
	logic                    timerFlag;
	logic                    sclMeta;
	logic                    sclSync;
	logic                    sclPrev;
	logic                    sclRise;
	logic                    wrAlmMin;
	logic                    wrAlmHour;
	logic                    wrAlmDay;
	logic                    wrPreLo;
	logic                    wrPreHi;
	logic                    wrExt;
	logic                    wrFlags;
	logic                    wrCtrl;
	logic                    teNew;
	logic                    teOld;
	logic                    srcHit;
	logic                    timerEvent;
	logic                    alarmMatch;
	logic                    alarmEvent;
	logic                    minOk;
	logic                    hourOk;
	logic                    dayOk;
	logic                    stopBit;
	logic                    wdaySel;
	logic [2:0]              tsel;
	logic                    irqActive;

	////////////////////////////////////////////////////////////////////////
	// Serial clock crossing and edge finder

	// Two flops before anyone looks at the serial clock
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			sclMeta <= 1'b0;
			sclSync <= 1'b0;
			sclPrev <= 1'b0;
		end
		else if (ce)
		begin
			sclMeta <= scl;
			sclSync <= sclMeta;
			sclPrev <= sclSync;
		end
	end

	// Rising edge of the synchronised serial clock
	assign sclRise = sclSync & ~sclPrev;

	////////////////////////////////////////////////////////////////////////
	// Write decode

	// Address decode for writes
	always_comb
	begin
		wrAlmMin  = 1'b0;
		wrAlmHour = 1'b0;
		wrAlmDay  = 1'b0;
		wrPreLo   = 1'b0;
		wrPreHi   = 1'b0;
		wrExt     = 1'b0;
		wrFlags   = 1'b0;
		wrCtrl    = 1'b0;
		if (regWr && regAddr == `RTCAI_ADDR_ALM_MIN)
			wrAlmMin = 1'b1;
		else if (regWr && regAddr == `RTCAI_ADDR_ALM_HOUR)
			wrAlmHour = 1'b1;
		else if (regWr && regAddr == `RTCAI_ADDR_ALM_DAY)
			wrAlmDay = 1'b1;
		else if (regWr && regAddr == `RTCAI_ADDR_PRE_LO)
			wrPreLo = 1'b1;
		else if (regWr && regAddr == `RTCAI_ADDR_PRE_HI)
			wrPreHi = 1'b1;
		else if (regWr && regAddr == `RTCAI_ADDR_EXT)
			wrExt = 1'b1;
		else if (regWr && regAddr == `RTCAI_ADDR_FLAGS)
			wrFlags = 1'b1;
		else if (regWr && regAddr == `RTCAI_ADDR_CTRL)
			wrCtrl = 1'b1;
	end

	// Control fields pulled out for readability
	assign stopBit = intCtrl[`RTCAI_BIT_STOP];
	assign wdaySel = extCtrl[`RTCAI_BIT_WEEKDAY_OR_DATE_SELECT];
	assign tsel    = extCtrl[2:0];
	assign teOld   = extCtrl[`RTCAI_BIT_TE];
	assign teNew   = regWdata[`RTCAI_BIT_TE];

	////////////////////////////////////////////////////////////////////////
	// Alarm registers

	// Stored whole; an excluded field is kept as storage and always matches
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			almMinute <= 8'h00;
			almHour   <= 8'h00;
			almDay    <= 8'h00;
		end
		else if (ce)
		begin
			if (wrAlmMin)
				almMinute <= regWdata;
			if (wrAlmHour)
				almHour <= regWdata;
			if (wrAlmDay)
				almDay <= regWdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer preset and control registers

	// Preset halves; software stops the timer before writing
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			preset <= 16'h0000;
		else if (ce)
		begin
			if (wrPreLo)
				preset[7:0] <= regWdata;
			if (wrPreHi)
				preset[15:8] <= regWdata;
		end
	end

	// Extension and interrupt control registers
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			extCtrl <= 8'h00;
			intCtrl <= 8'h00;
		end
		else if (ce)
		begin
			if (wrExt)
				extCtrl <= regWdata;
			if (wrCtrl)
				intCtrl <= regWdata & `RTCAI_CTRL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Countdown sequencer

	// Selected source tick; codes above the last give no ticks
	assign srcHit = (tsel <= `RTCAI_TSEL_MAX) && srcTick[tsel]
		&& !intCtrl[`RTCAI_BIT_TSTP]
		&& !(stopBit && tsel != `RTCAI_TSEL_FAST);

	assign timerEvent = (tmrState == rtcai_pkg::TMR_RUN) && srcHit
		&& count == 16'h0001;

	// Arm on the enable write, start on the following ack edge
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			tmrState <= rtcai_pkg::TMR_IDLE;
			count    <= 16'h0000;
		end
		else if (ce)
		begin
			case (tmrState)
				rtcai_pkg::TMR_IDLE:
				begin
					if (wrExt && teNew && !teOld)
						tmrState <= rtcai_pkg::TMR_ARMED;
				end
				rtcai_pkg::TMR_ARMED:
				begin
					if (wrExt && !teNew)
						tmrState <= rtcai_pkg::TMR_IDLE;
					else if (sclRise)
					begin
						tmrState <= rtcai_pkg::TMR_RUN;
						count    <= preset;
					end
				end
				rtcai_pkg::TMR_RUN:
				begin
					if (wrExt && !teNew)
						tmrState <= rtcai_pkg::TMR_IDLE;
					else if (timerEvent)
						count <= preset;
					else if (srcHit && count != 16'h0000)
						count <= count - 16'h0001;
				end
				default:
					tmrState <= rtcai_pkg::TMR_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Alarm comparison

	// Minute and hour each match when excluded or equal to the counter
	assign minOk  = almMinute[`RTCAI_BIT_EXCL]
		|| almMinute[6:0] == curMinute;
	assign hourOk = almHour[`RTCAI_BIT_EXCL]
		|| almHour[5:0] == curHour;

	// Weekday bitmap or BCD date, by the select bit
	always_comb
	begin
		dayOk = 1'b0;
		if (almDay[`RTCAI_BIT_EXCL])
			dayOk = 1'b1;
		else if (!wdaySel)
			dayOk = curWeekday <= 3'h6 && almDay[curWeekday];
		else
			dayOk = almDay[5:0] == curDate;
	end

	// All excluded gives one hit per minute tick while the stop bit is clear
	assign alarmMatch = minOk && hourOk && dayOk;

	// Only a rollover into the value counts, never a write
	assign alarmEvent = minuteTick && alarmMatch
		&& !stopBit;

	////////////////////////////////////////////////////////////////////////
	// Event flags

	// Set wins over a clear in the same cycle; writing one does nothing
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			alarmFlag <= 1'b0;
			timerFlag <= 1'b0;
		end
		else if (ce)
		begin
			if (alarmEvent)
				alarmFlag <= 1'b1;
			else if (wrFlags && !regWdata[`RTCAI_BIT_AF])
				alarmFlag <= 1'b0;
			if (timerEvent)
				timerFlag <= 1'b1;
			else if (wrFlags && !regWdata[`RTCAI_BIT_TF])
				timerFlag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer request pulse

	// Fixed length low pulse; clearing the flag does not shorten it
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			pulseCnt <= 19'h00000;
		else if (ce)
		begin
			if (timerEvent && tsel == `RTCAI_TSEL_FAST)
				pulseCnt <= 19'(TRTN_FAST_CYC);
			else if (timerEvent)
				pulseCnt <= 19'(TRTN_SLOW_CYC);
			else if (pulseCnt != 19'h00000)
				pulseCnt <= pulseCnt - 19'h00001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open-drain request pin

	// Alarm low holds with the flag; gates only steer the pin
	assign irqActive = (alarmFlag && intCtrl[`RTCAI_BIT_AIE])
		|| (pulseCnt != 19'h00000 && intCtrl[`RTCAI_BIT_TIE]);

	// Registered pin drive, enable low pulls the line low
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			irqOut <= 1'b0;
			irqOeN <= 1'b1;
		end
		else if (ce)
		begin
			irqOut <= 1'b0;
			irqOeN <= !irqActive;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Read mux; unmapped offsets answer zero
	always_comb
	begin
		next_rdata = 8'h00;
		if (regAddr == `RTCAI_ADDR_ALM_MIN)
			next_rdata = almMinute;
		else if (regAddr == `RTCAI_ADDR_ALM_HOUR)
			next_rdata = almHour & 8'hBF;
		else if (regAddr == `RTCAI_ADDR_ALM_DAY)
			next_rdata = wdaySel ? (almDay & 8'hBF) : almDay;
		else if (regAddr == `RTCAI_ADDR_PRE_LO)
			next_rdata = teOld ? count[7:0] : preset[7:0];
		else if (regAddr == `RTCAI_ADDR_PRE_HI)
			next_rdata = teOld ? count[15:8] : preset[15:8];
		else if (regAddr == `RTCAI_ADDR_EXT)
			next_rdata = extCtrl;
		else if (regAddr == `RTCAI_ADDR_FLAGS)
		begin
			next_rdata[`RTCAI_BIT_TF] = timerFlag;
			next_rdata[`RTCAI_BIT_AF] = alarmFlag;
		end
		else if (regAddr == `RTCAI_ADDR_CTRL)
			next_rdata = intCtrl;
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			regRdata <= 8'h00;
		else if (ce)
			regRdata <= regRd ? next_rdata : 8'h00;
	end

endmodule // rtcai_alarm_timer

// ### src/rtcai_params.svh
// Constants of the alarm and periodic timer interrupt block
`ifndef RTCAI_PARAMS_SVH
`define RTCAI_PARAMS_SVH
`define RTCAI_ADDR_ALM_MIN  8'h08
`define RTCAI_ADDR_ALM_HOUR 8'h09
`define RTCAI_ADDR_ALM_DAY  8'h0A
`define RTCAI_ADDR_PRE_LO   8'h0B
`define RTCAI_ADDR_PRE_HI   8'h0C
`define RTCAI_ADDR_EXT      8'h0D
`define RTCAI_ADDR_FLAGS    8'h0E
`define RTCAI_ADDR_CTRL     8'h0F
`define RTCAI_BIT_EXCL      7
`define RTCAI_BIT_UNIMP     6
`define RTCAI_BIT_TE        4
`define RTCAI_BIT_WEEKDAY_OR_DATE_SELECT      3
`define RTCAI_BIT_TF        4
`define RTCAI_BIT_AF        3
`define RTCAI_BIT_TIE       4
`define RTCAI_BIT_AIE       3
`define RTCAI_BIT_TSTP      2
`define RTCAI_BIT_STOP      1
`define RTCAI_CTRL_MASK     8'h3E
`define RTCAI_TSEL_FAST     3'h0
`define RTCAI_TSEL_MAX      3'h4
`define RTCAI_CLK_NS        25
`define RTCAI_TRTN_FAST_NS  122000
`define RTCAI_TRTN_SLOW_NS  7813000
`define RTCAI_TRTN_FAST_CYC (`RTCAI_TRTN_FAST_NS / `RTCAI_CLK_NS)
`define RTCAI_TRTN_SLOW_CYC (`RTCAI_TRTN_SLOW_NS / `RTCAI_CLK_NS)
`endif

// ### src/rtcai_pkg.sv
// Types shared by the alarm and periodic timer interrupt block
package rtcai_pkg;
	typedef logic [7:0] rtcai_byte_t;
	typedef logic [15:0] rtcai_count_t;
	typedef logic [18:0] rtcai_pulse_t;
	// Countdown sequencer, one-hot
	typedef enum logic [2:0]
	{
		TMR_IDLE  = 3'b001,
		TMR_ARMED = 3'b010,
		TMR_RUN   = 3'b100
	} rtcai_tmr_e;
endpackage
